// ===== rtl/usb_line_sync.sv
// Package of shared constants and the three-stage pin input synchroniser.
package usb_fe_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SUSPEND_TIME_US = 3000;
  localparam int SUSPEND_CYCLES = SUSPEND_TIME_US * CLK_MHZ;
  localparam int BIT_DIV = 4;
  localparam logic [1:0] RX_SAMPLE_PHASE = 2'h1;
  localparam logic [1:0] TX_LAST_PHASE = 2'h3;
  localparam logic TX_IDLE_LEVEL = 1'h1;
  localparam logic SPEED_RESET = 1'h0;
endpackage

`timescale 1ns/1ps
`default_nettype none

module usb_line_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire [WIDTH-1:0] differ = s2 ^ s3;

  // A bit only moves once two settled stages agree, which filters a single-cycle glitch.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s2 & ~differ) | (q & differ);
    end
  end
endmodule

`default_nettype wire

// ===== rtl/usb_front_end_interface.sv
// USB front end interface: bit timing, receive sampling, NRZI transmit and suspend.
// What this block does
// - Module clock recovers data, divides by four
// - Speed pin follows software speed bit
// - Both single-ended inputs low means SE0
// - Received data comes from differential input
// - Idle three milliseconds raises suspend indication
// - Suspend holds until host wake-up arrives
// - Leaving suspend drops the suspend indication
// - Transmit as NRZI pair on two outputs
// - Active-low driver enable, low while driving
`timescale 1ns/1ps
`default_nettype none

module usb_front_end_interface
  import usb_fe_pkg::*;
#(
  parameter int SUSPEND_COUNT = SUSPEND_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic usb_module_clk,
  input wire logic speed_ctrl,
  input wire logic rx_dplus_single_ended,
  input wire logic rx_dminus_single_ended,
  input wire logic rx_data,
  input wire logic tx_active,
  input wire logic tx_bit,
  input wire logic tx_se0,
  output logic tx_ready,
  output logic rx_bit,
  output logic rx_bit_valid,
  output logic se0_detect,
  output logic speed_select_bit,
  output logic suspend_indication,
  output logic tx_dplus_out,
  output logic tx_dminus_out,
  output logic tx_driver_enable_n
);
  localparam int CW = $clog2(SUSPEND_COUNT + 1);
  localparam logic [CW-1:0] IDLE_LAST = CW'(SUSPEND_COUNT - 1);

  logic [3:0] pins_q;
  logic clk_prev;
  logic rx_prev;
  logic se0_prev;
  logic [1:0] rx_phase;
  logic [1:0] tx_phase;
  logic tx_level;
  logic [CW-1:0] idle_count;

  // D+ and receive data pass inverted, so the all-zero reset of the stages reads as idle J.
  usb_line_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({usb_module_clk, ~rx_data, ~rx_dplus_single_ended, rx_dminus_single_ended}),
    .q(pins_q)
  );

  wire mod_clk_q = pins_q[3];
  wire rx_q = ~pins_q[2];
  wire mod_tick = mod_clk_q & ~clk_prev;
  wire se0_now = pins_q[1] & ~pins_q[0];
  wire rx_edge = rx_q ^ rx_prev;
  wire se0_change = se0_now ^ se0_prev;
  wire bus_wake = rx_edge | se0_change;
  wire rx_sample = mod_tick & (rx_phase == RX_SAMPLE_PHASE);
  wire bit_tick = mod_tick & (tx_phase == TX_LAST_PHASE);
  wire tx_go = bit_tick & tx_active & ~suspend_indication;
  wire idle_full = (idle_count == IDLE_LAST);
  wire activity = bus_wake | tx_active;
  wire next_level = tx_bit ? tx_level : ~tx_level;
  wire next_enable_n = ~(tx_active & ~suspend_indication);

  assign tx_ready = tx_go;

  // The receive phase restarts on every data edge, so sampling tracks the sender's clock.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clk_prev <= 1'h0;
      rx_prev <= 1'h1;
      se0_prev <= 1'h0;
      rx_phase <= 2'h0;
      tx_phase <= 2'h0;
    end
    else
    begin
      clk_prev <= mod_clk_q;
      rx_prev <= rx_q;
      se0_prev <= se0_now;
      if (rx_edge)
      begin
        rx_phase <= 2'h0;
      end
      else if (mod_tick)
      begin
        rx_phase <= rx_phase + 2'h1;
      end
      if (mod_tick)
      begin
        tx_phase <= tx_phase + 2'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_bit <= 1'h0;
      rx_bit_valid <= 1'h0;
      se0_detect <= 1'h0;
      speed_select_bit <= SPEED_RESET;
    end
    else
    begin
      rx_bit_valid <= rx_sample & ~tx_active & ~suspend_indication & ~se0_now;
      if (rx_sample)
      begin
        rx_bit <= rx_q;
      end
      se0_detect <= se0_now;
      speed_select_bit <= speed_ctrl;
    end
  end

  // Suspend waits on a full idle count and leaves on any bus change from the host.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      idle_count <= '0;
      suspend_indication <= 1'h0;
    end
    else if (suspend_indication)
    begin
      idle_count <= '0;
      if (bus_wake)
      begin
        suspend_indication <= 1'h0;
      end
    end
    else if (activity)
    begin
      idle_count <= '0;
    end
    else if (idle_full)
    begin
      suspend_indication <= 1'h1;
    end
    else
    begin
      idle_count <= idle_count + CW'(1);
    end
  end

  // Outputs return to the idle J level between packets, so a new packet starts from J.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_level <= TX_IDLE_LEVEL;
      tx_dplus_out <= TX_IDLE_LEVEL;
      tx_dminus_out <= ~TX_IDLE_LEVEL;
      tx_driver_enable_n <= 1'h1;
    end
    else
    begin
      tx_driver_enable_n <= next_enable_n;
      if (!tx_active || suspend_indication)
      begin
        tx_level <= TX_IDLE_LEVEL;
        tx_dplus_out <= TX_IDLE_LEVEL;
        tx_dminus_out <= ~TX_IDLE_LEVEL;
      end
      else if (tx_go && tx_se0)
      begin
        tx_dplus_out <= 1'h0;
        tx_dminus_out <= 1'h0;
      end
      else if (tx_go)
      begin
        tx_level <= next_level;
        tx_dplus_out <= next_level;
        tx_dminus_out <= ~next_level;
      end
    end
  end

  a_se0_detect: assert property (@(posedge clk) disable iff (rst)
    se0_now |=> se0_detect) else $error("SE0 not flagged");
  a_speed_follow: assert property (@(posedge clk) disable iff (rst)
    ##1 speed_select_bit == $past(speed_ctrl)) else $error("Speed pin wrong");
  a_bit_spacing: assert property (@(posedge clk) disable iff (rst)
    bit_tick |=> !bit_tick [*6]) else $error("Bit clock too fast");
  a_suspend_entry: assert property (@(posedge clk) disable iff (rst)
    !suspend_indication && idle_full && !activity |=> suspend_indication)
    else $error("Suspend not entered");
  a_suspend_early: assert property (@(posedge clk) disable iff (rst)
    $rose(suspend_indication) |-> $past(idle_count) == IDLE_LAST)
    else $error("Suspend too early");
  a_suspend_hold: assert property (@(posedge clk) disable iff (rst)
    suspend_indication && !bus_wake |=> suspend_indication)
    else $error("Suspend dropped without wake");
  a_wake_exit: assert property (@(posedge clk) disable iff (rst)
    suspend_indication && bus_wake |=> !suspend_indication)
    else $error("Wake ignored");
  a_enable_idle: assert property (@(posedge clk) disable iff (rst)
    (!tx_active || suspend_indication) |=> tx_driver_enable_n)
    else $error("Driver enabled while idle");
  a_enable_send: assert property (@(posedge clk) disable iff (rst)
    tx_active && !suspend_indication |=> !tx_driver_enable_n)
    else $error("Driver not enabled");
  a_nrzi_zero: assert property (@(posedge clk) disable iff (rst)
    tx_go && !tx_se0 && !tx_bit |=> tx_dplus_out != $past(tx_level))
    else $error("Zero did not toggle");
  a_nrzi_one: assert property (@(posedge clk) disable iff (rst)
    tx_go && !tx_se0 && tx_bit && $past(tx_active) |=> tx_dplus_out == $past(tx_level))
    else $error("One toggled");
  a_pair_diff: assert property (@(posedge clk) disable iff (rst)
    (tx_dplus_out || tx_dminus_out) |-> tx_dplus_out != tx_dminus_out)
    else $error("Pair not differential");

  c_suspend: cover property (@(posedge clk) disable iff (rst) $rose(suspend_indication));
  c_wake: cover property (@(posedge clk) disable iff (rst) $fell(suspend_indication));
  c_tx_bit: cover property (@(posedge clk) disable iff (rst) tx_go && !tx_bit);
  c_rx_bit: cover property (@(posedge clk) disable iff (rst) rx_bit_valid);
endmodule

`default_nettype wire

// ===== verification/usb_fe_model.sv
// Front end model: bus drivers, line receivers and host line levels.
`timescale 1ns/1ps
`default_nettype none
module usb_fe_model (
  input wire logic tx_dp,
  input wire logic tx_dm,
  input wire logic tx_en_n,
  input wire logic susp,
  input wire logic host_dp,
  input wire logic host_dm,
  output logic rx_dp,
  output logic rx_dm,
  output logic rx_d,
  output logic low_power
);
  wire logic drive = !tx_en_n;
  assign rx_dp = drive ? tx_dp : host_dp;
  assign rx_dm = drive ? tx_dm : host_dm;
  assign rx_d = rx_dp & !rx_dm;
  // Receivers stay awake in low power, or a host wake-up could never arrive.
  assign low_power = susp;
endmodule
`default_nettype wire

// ===== verification/tb_usb_front_end_interface.sv
// Testbench for the USB front end interface with a front end model.
`timescale 1ns/1ps
`default_nettype none
module tb_usb_front_end_interface;
  import usb_fe_pkg::*;
  localparam int SUSP_N = 200;
  logic clk, rst, mclk, spd, tx_active, tx_bit, tx_se0, h_dp, h_dm, r_dp, r_dm, r_d;
  logic tx_ready, rx_bit, rx_v, se0, spd_o, susp, t_dp, t_dm, en_n, lvl, b, s, lp;
  int fail_count = 0, n_tests = 0, seed = 6, gap, i;
  usb_front_end_interface #(.SUSPEND_COUNT(SUSP_N)) dut_u (.clk(clk), .rst(rst),
    .usb_module_clk(mclk), .speed_ctrl(spd), .rx_dplus_single_ended(r_dp),
    .rx_dminus_single_ended(r_dm), .rx_data(r_d), .tx_active(tx_active), .tx_bit(tx_bit),
    .tx_se0(tx_se0), .tx_ready(tx_ready), .rx_bit(rx_bit), .rx_bit_valid(rx_v),
    .se0_detect(se0), .speed_select_bit(spd_o), .suspend_indication(susp),
    .tx_dplus_out(t_dp), .tx_dminus_out(t_dm), .tx_driver_enable_n(en_n));
  usb_fe_model fe_u (.tx_dp(t_dp), .tx_dm(t_dm), .tx_en_n(en_n), .susp(susp),
    .host_dp(h_dp), .host_dm(h_dm), .rx_dp(r_dp), .rx_dm(r_dm), .rx_d(r_d), .low_power(lp));
  function automatic logic nrzi(input logic l, input logic bit_in);
    return bit_in ? l : ~l;
  endfunction
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Module clock period is not a multiple of clk, so sampling phase drifts.
  initial
  begin
    mclk = 1'b0;
    forever #26 mclk = ~mclk;
  end
  initial
  begin
    #50000;
    fail_count++;
    end_sim();
  end
  initial
  begin
    {rst, spd, tx_active, tx_bit, tx_se0, h_dp, h_dm} = 7'h4a;
    cyc(4);
    rst = 1'b0;
    chk(en_n, 1'b1);
    chk(t_dp, TX_IDLE_LEVEL);
    for (i = 0; i < 6; i++)
    begin
      spd = 1'($random(seed));
      cyc(1);
      chk(spd_o, spd);
    end
    {h_dp, h_dm} = 2'h0;
    cyc(6);
    chk(se0, 1'b1);
    h_dp = 1'b1;
    cyc(6);
    chk(se0, 1'b0);
    lvl = 1'b1;
    for (i = 0; i < 8; i++)
    begin
      lvl = ~lvl;
      {h_dp, h_dm} = {lvl, ~lvl};
      cyc(7);
      for (gap = 0; gap < 60 && rx_v !== 1'b1; gap++)
        cyc(1);
      chk(rx_v, 1'b1);
      chk(rx_bit, lvl);
    end
    {h_dp, h_dm} = 2'h2;
    tx_active = 1'b1;
    cyc(2);
    chk(en_n, 1'b0);
    lvl = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      tx_bit = 1'($random(seed));
      tx_se0 = (i == 5);
      gap = 0;
      do
      begin
        @(negedge clk);
        gap++;
      end while (tx_ready !== 1'b1 && gap < 40);
      if (i > 0)
        chk(gap >= 19 && gap <= 22, 1'b1);
      b = tx_bit;
      s = tx_se0;
      cyc(2);
      lvl = s ? lvl : nrzi(lvl, b);
      chk(t_dp, !s && lvl);
      chk(t_dm, !s && !lvl);
    end
    tx_active = 1'b0;
    cyc(2);
    chk(en_n, 1'b1);
    cyc(SUSP_N - 12);
    chk(susp, 1'b0);
    cyc(22);
    chk(susp, 1'b1);
    tx_active = 1'b1;
    cyc(8);
    chk(en_n, 1'b1);
    chk(susp, 1'b1);
    chk(lp, 1'b1);
    tx_active = 1'b0;
    {h_dp, h_dm} = 2'h1;
    cyc(8);
    chk(susp, 1'b0);
    chk(lp, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
